/* hdl/shs_sequencer.sv */
// Handler trigger, result output and system settings sequencer.
// ==========================================================
`timescale 1ns/10ps

module shs_sequencer #(
  parameter int US_CYCLES = shs_pkg::SHS_US_CYC
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Comparator result of the current measurement.
  input  wire logic [2:0]  bin_judge,
  // Handler pins.
  input  wire logic        meas_trig_n,
  output logic             bin1_good_n,
  output logic             bin2_good_n,
  output logic             bin3_good_n,
  output logic             fail_n,
  output logic             eoc_n,
  output logic             handler_supply_select,
  // Instrument status.
  output logic             beeper_en,
  output logic             sampling
);
  import shs_pkg::*;

  if (US_CYCLES < 1) begin : g_bad_cycles
    $error("US_CYCLES must be at least one");
  end

  if (US_CYCLES > 65536) begin : g_big_cycles
    $error("US_CYCLES must fit the 16-bit prescaler");
  end

  if (SHS_SLOTS > 31) begin : g_bad_slots
    $error("Slot count must fit the 5-bit slot field");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_SETTLE, ST_PROC} shs_state_t;

  // ==========================================================
  // Functions.
  function automatic logic [31:0] ms_to_us(input logic [15:0] ms, input int k);
    ms_to_us = 32'(ms) * 32'(k) * 32'(SHS_US_PER_MS);
  endfunction

  function automatic logic [31:0] sample_us(input logic [1:0] spd, input logic comp,
                                            input logic l60, input logic [15:0] dly);
    logic [31:0] t;
    t = 32'h0;
    if (!comp) begin
      case (shs_speed_t'(spd))
        SHS_FAST:   t = 32'(SHS_T_FAST_US);
        SHS_MEDIUM: t = l60 ? 32'(SHS_T_MED60_US) : 32'(SHS_T_MED50_US);
        SHS_SLOW1:  t = 32'(SHS_T_SLOW1_US);
        default:    t = 32'(SHS_T_SLOW2_US);
      endcase
    end else begin
      case (shs_speed_t'(spd))
        SHS_FAST:   t = 32'(SHS_T_CFAST_US) + ms_to_us(dly, 1);
        SHS_MEDIUM: t = (l60 ? 32'(SHS_T_CMED60_US) : 32'(SHS_T_CMED50_US))
                        + ms_to_us(dly, 1);
        SHS_SLOW1:  t = 32'(SHS_T_CSLOW1_US)
                        + ms_to_us(dly, l60 ? SHS_K_SLOW1_60 : SHS_K_SLOW1_50);
        default:    t = 32'(SHS_T_CSLOW2_US)
                        + ms_to_us(dly, l60 ? SHS_K_SLOW2_60 : SHS_K_SLOW2_50);
      endcase
    end
    sample_us = t;
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0]            a,
                                            input logic [SHS_CTRL_W-1:0] c,
                                            input logic                  l60,
                                            input logic [15:0]           d,
                                            input logic [2:0]            en,
                                            input logic [31:0]           st,
                                            input logic [3:0]            res);
    logic [31:0] w;
    w = 32'h0;
    if (a == SHS_CTRL_OFS) begin
      w = {22'h0, c};
    end else if (a == SHS_LFREQ_OFS) begin
      w = {24'h0, l60 ? SHS_LF60 : SHS_LF50};
    end else if (a == SHS_DELAY_OFS) begin
      w = {16'h0, d};
    end else if (a == SHS_BINEN_OFS) begin
      w = {29'h0, en};
    end else if (a == SHS_STATUS_OFS) begin
      w = st;
    end else if (a == SHS_RESULT_OFS) begin
      w = {28'h0, res};
    end
    read_word = w;
  endfunction

  // ==========================================================
  // Registers.
  logic [SHS_CTRL_W-1:0] ctrl_ff;
  logic [SHS_CTRL_W-1:0] nxt_ctrl;
  logic                  line60_ff;
  logic                  nxt_line60;
  logic [15:0]           delay_ff;
  logic [15:0]           nxt_delay;
  logic [2:0]            binen_ff;
  logic [2:0]            nxt_binen;
  logic [29:0]           slot_mem [0:SHS_SLOTS-1];
  logic [SHS_SLOTS-1:0]  slot_vld_ff;
  logic [2:0]            result_ff;
  logic                  fresh_ff;
  logic                  bus_run_ff;
  logic                  trig_prev_ff;
  shs_state_t            state_ff;
  shs_state_t            nxt_state;
  logic [31:0]           remain_ff;
  logic [31:0]           nxt_remain;
  logic [15:0]           pre_ff;
  logic                  good1_n_ff;
  logic                  good2_n_ff;
  logic                  good3_n_ff;
  logic                  fail_n_ff;
  logic                  eoc_n_ff;

  // ==========================================================
  // APB decode.
  wire        wr_en    = psel & penable & pwrite;
  wire        rd_acc   = psel & penable & ~pwrite;
  wire        hit_ctrl = (paddr == SHS_CTRL_OFS);
  wire        hit_lf   = (paddr == SHS_LFREQ_OFS);
  wire        hit_dly  = (paddr == SHS_DELAY_OFS);
  wire        hit_ben  = (paddr == SHS_BINEN_OFS);
  wire        hit_cmd  = (paddr == SHS_CMD_OFS);
  wire        hit_st   = (paddr == SHS_STATUS_OFS);
  wire        hit_res  = (paddr == SHS_RESULT_OFS);
  wire        hit_any  = hit_ctrl | hit_lf | hit_dly | hit_ben | hit_cmd | hit_st | hit_res;
  wire        cmd_wr   = wr_en & hit_cmd;
  wire [4:0]  cmd_slot = pwdata[SHS_CMD_SLOT_LO +: 5];
  wire [4:0]  cmd_name = pwdata[SHS_CMD_NAME_LO +: 5];
  wire        slot_ok  = (cmd_slot != 5'h00) && (cmd_slot <= 5'(SHS_SLOTS));
  wire [4:0]  slot_idx = cmd_slot - 5'h01;
  wire        do_save  = cmd_wr & pwdata[SHS_CMD_SAVE] & slot_ok
                         & (cmd_name != 5'h00) & (cmd_name <= SHS_NAME_MAX);
  wire        do_load  = cmd_wr & pwdata[SHS_CMD_LOAD] & slot_ok
                         & slot_vld_ff[slot_idx];
  wire        do_freset = cmd_wr & pwdata[SHS_CMD_FRESET];
  wire [29:0] cur_set  = {binen_ff, delay_ff, line60_ff, ctrl_ff};
  wire [29:0] ld_set   = slot_mem[slot_idx];

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // ==========================================================
  // Settings update.
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_line60 = line60_ff;
    nxt_delay  = delay_ff;
    nxt_binen  = binen_ff;
    if (do_freset) begin
      nxt_ctrl   = SHS_CTRL_RST;
      nxt_line60 = 1'b0;
      nxt_delay  = SHS_DELAY_RST;
      nxt_binen  = SHS_BINEN_RST;
    end else if (do_load) begin
      {nxt_binen, nxt_delay, nxt_line60, nxt_ctrl} = ld_set;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        nxt_ctrl = pwdata[SHS_CTRL_W-1:0];
      end else if (hit_lf) begin
        if (pwdata[7:0] == SHS_LF50) begin
          nxt_line60 = 1'b0;
        end else if (pwdata[7:0] == SHS_LF60) begin
          nxt_line60 = 1'b1;
        end
      end else if (hit_dly) begin
        nxt_delay = pwdata[15:0];
      end else if (hit_ben) begin
        nxt_binen = pwdata[2:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff     <= SHS_CTRL_RST;
      line60_ff   <= 1'b0;
      delay_ff    <= SHS_DELAY_RST;
      binen_ff    <= SHS_BINEN_RST;
      slot_vld_ff <= '0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      line60_ff <= nxt_line60;
      delay_ff  <= nxt_delay;
      binen_ff  <= nxt_binen;
      if (do_save) begin
        slot_vld_ff[slot_idx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_save) begin
      slot_mem[slot_idx] <= cur_set;
    end
  end

  // ==========================================================
  // Trigger sources.
  wire idle      = (state_ff == ST_IDLE);
  wire ext_fall  = trig_prev_ff & ~meas_trig_n;
  wire ext_start = ctrl_ff[SHS_EXT_TRIG] & ext_fall;
  wire bus_start = cmd_wr & pwdata[SHS_CMD_TRIG]
                   & ctrl_ff[SHS_CONT_INIT] & ctrl_ff[SHS_SRC_BUS];
  wire start     = idle & (ext_start | bus_start);
  wire us_tick   = (pre_ff == 16'(US_CYCLES - 1));
  wire expired   = (remain_ff == 32'h0);
  wire [31:0] smp_us  = sample_us(ctrl_ff[SHS_SPEED_LO +: 2], ctrl_ff[SHS_OFS_COMP],
                                  line60_ff, delay_ff);
  wire [31:0] proc_us = ctrl_ff[SHS_DISP_ON] ? 32'(SHS_T_PROC_ON_US - SHS_T_OUT_US)
                                             : 32'(SHS_T_PROC_OFF_US - SHS_T_OUT_US);
  wire [2:0]  good    = bin_judge & binen_ff;
  wire        upd     = (state_ff == ST_SETTLE) & expired;

  // ==========================================================
  // Measurement sequence.
  always_comb begin
    nxt_state  = state_ff;
    nxt_remain = (us_tick && !expired) ? remain_ff - 32'h1 : remain_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state  = ST_DELAY;
          nxt_remain = ms_to_us(delay_ff, 1);
        end
      end
      ST_DELAY: begin
        if (expired) begin
          nxt_state  = ST_SAMPLE;
          nxt_remain = smp_us;
        end
      end
      ST_SAMPLE: begin
        if (expired) begin
          nxt_state  = ST_SETTLE;
          nxt_remain = 32'(SHS_T_OUT_US);
        end
      end
      ST_SETTLE: begin
        if (expired) begin
          nxt_state  = ST_PROC;
          nxt_remain = proc_us;
        end
      end
      default: begin
        if (expired) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff     <= ST_IDLE;
      remain_ff    <= 32'h0;
      pre_ff       <= 16'h0;
      trig_prev_ff <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      remain_ff    <= nxt_remain;
      pre_ff       <= (us_tick || nxt_state != state_ff) ? 16'h0 : pre_ff + 16'h1;
      trig_prev_ff <= meas_trig_n;
    end
  end

  // ==========================================================
  // Handler outputs and result buffer.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      good1_n_ff <= 1'b1;
      good2_n_ff <= 1'b1;
      good3_n_ff <= 1'b1;
      fail_n_ff  <= 1'b1;
      eoc_n_ff   <= 1'b1;
      result_ff  <= 3'h0;
      fresh_ff   <= 1'b0;
      bus_run_ff <= 1'b0;
    end else begin
      if (start) begin
        eoc_n_ff   <= 1'b1;
        bus_run_ff <= bus_start;
      end else if (state_ff == ST_PROC && expired) begin
        eoc_n_ff <= 1'b0;
      end
      if (upd) begin
        good1_n_ff <= ~good[0];
        good2_n_ff <= ~good[1];
        good3_n_ff <= ~good[2];
        fail_n_ff  <= |good;
        result_ff  <= good;
      end
      if (upd && bus_run_ff) begin
        fresh_ff <= 1'b1;
      end else if (rd_acc && hit_res) begin
        fresh_ff <= 1'b0;
      end
    end
  end

  assign bin1_good_n           = good1_n_ff;
  assign bin2_good_n           = good2_n_ff;
  assign bin3_good_n           = good3_n_ff;
  assign fail_n                = fail_n_ff;
  assign eoc_n                 = eoc_n_ff;
  assign handler_supply_select = ctrl_ff[SHS_SUPPLY_EXT];
  assign beeper_en             = ctrl_ff[SHS_BEEPER];
  assign sampling              = (state_ff == ST_SAMPLE);

  // ==========================================================
  // Read data.
  wire [31:0] rd_status = {24'h0, ~eoc_n_ff, fresh_ff, sampling, ~idle, 1'b0, state_ff};
  wire [31:0] rd_mux    = read_word(paddr, ctrl_ff, line60_ff, delay_ff, binen_ff, rd_status,
                                    {fresh_ff, result_ff});

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule

/* shared/shs_pkg.sv */
// Constants shared by the sorting handler sequencer.
package shs_pkg;

  // ==========================================================
  // Register map.
  localparam logic [7:0] SHS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SHS_LFREQ_OFS  = 8'h04;
  localparam logic [7:0] SHS_DELAY_OFS  = 8'h08;
  localparam logic [7:0] SHS_BINEN_OFS  = 8'h0c;
  localparam logic [7:0] SHS_CMD_OFS    = 8'h10;
  localparam logic [7:0] SHS_STATUS_OFS = 8'h14;
  localparam logic [7:0] SHS_RESULT_OFS = 8'h18;

  // ==========================================================
  // Control register fields.
  localparam int SHS_CTRL_W      = 10;
  localparam int SHS_EXT_TRIG    = 0;
  localparam int SHS_DISP_ON     = 1;
  localparam int SHS_OFS_COMP    = 2;
  localparam int SHS_SPEED_LO    = 3;
  localparam int SHS_BEEPER      = 5;
  localparam int SHS_SUPPLY_EXT  = 6;
  localparam int SHS_CONT_INIT   = 7;
  localparam int SHS_SRC_BUS     = 8;
  localparam int SHS_SPARE       = 9;
  localparam logic [9:0] SHS_CTRL_RST = 10'h023;

  // Command register fields.
  localparam int SHS_CMD_TRIG    = 0;
  localparam int SHS_CMD_FRESET  = 1;
  localparam int SHS_CMD_SAVE    = 2;
  localparam int SHS_CMD_LOAD    = 3;
  localparam int SHS_CMD_SLOT_LO = 8;
  localparam int SHS_CMD_NAME_LO = 16;

  // ==========================================================
  // Settings defaults and limits.
  localparam logic [7:0]  SHS_LF50       = 8'h32;
  localparam logic [7:0]  SHS_LF60       = 8'h3c;
  localparam logic [15:0] SHS_DELAY_RST  = 16'h0000;
  localparam logic [2:0]  SHS_BINEN_RST  = 3'h7;
  localparam int          SHS_SLOTS      = 30;
  localparam logic [4:0]  SHS_NAME_MAX   = 5'h0f;

  // ==========================================================
  // Timing; durations in microseconds, except the clock period in nanoseconds.
  localparam int SHS_CLK_PERIOD_NS = 8;
  localparam int SHS_US_CYC        = (1000 + SHS_CLK_PERIOD_NS - 1) / SHS_CLK_PERIOD_NS;
  localparam int SHS_US_PER_MS     = 1000;
  localparam int SHS_T_FAST_US     = 5000;
  localparam int SHS_T_MED50_US    = 20000;
  localparam int SHS_T_MED60_US    = 16600;
  localparam int SHS_T_SLOW1_US    = 110000;
  localparam int SHS_T_SLOW2_US    = 450000;
  localparam int SHS_T_CFAST_US    = 10000;
  localparam int SHS_T_CMED50_US   = 40000;
  localparam int SHS_T_CMED60_US   = 33000;
  localparam int SHS_T_CSLOW1_US   = 220000;
  localparam int SHS_T_CSLOW2_US   = 900000;
  localparam int SHS_K_SLOW1_50    = 9;
  localparam int SHS_K_SLOW1_60    = 11;
  localparam int SHS_K_SLOW2_50    = 39;
  localparam int SHS_K_SLOW2_60    = 47;
  localparam int SHS_T_OUT_US      = 2000;
  localparam int SHS_T_PROC_ON_US  = 22000;
  localparam int SHS_T_PROC_OFF_US = 5000;

  typedef enum logic [1:0] {SHS_FAST, SHS_MEDIUM, SHS_SLOW1, SHS_SLOW2} shs_speed_t;

endpackage

/* verif/shs_checker.sv */
// Concurrent assertions on the sorting handler sequencer ports.
`timescale 1ns/10ps
module shs_checker
  import shs_pkg::*;
#(
  parameter int US_CYCLES = 1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Bus strobes.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // Handler pins and status.
  input wire logic meas_trig_n,
  input wire logic bin1_good_n,
  input wire logic bin2_good_n,
  input wire logic bin3_good_n,
  input wire logic fail_n,
  input wire logic eoc_n,
  input wire logic handler_supply_select,
  input wire logic beeper_en,
  input wire logic sampling
);
  // ==========================================================
  // Phase counters.
  localparam int SET_MIN  = SHS_T_OUT_US * US_CYCLES - 2;
  localparam int PROC_MIN = SHS_T_PROC_OFF_US * US_CYCLES - 4;
  localparam int SAMP_MIN = SHS_T_FAST_US * US_CYCLES - 2;
  int              hi_ff;
  int              lo_ff;
  wire logic       bus_wr = psel && penable && pwrite;
  wire logic [3:0] outs   = {bin1_good_n, bin2_good_n, bin3_good_n, fail_n};
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_ff <= 0;
      lo_ff <= 0;
    end else begin
      hi_ff <= sampling ? hi_ff + 1 : 0;
      lo_ff <= sampling ? 0 : lo_ff + 1;
    end
  end
  // ==========================================================
  // Assertions.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_start;
    $rose(eoc_n);
  endsequence
  sequence s_done;
    $fell(eoc_n);
  endsequence
  a_eoc_start: assert property (
    s_start |-> !$past(meas_trig_n) || $past(bus_wr) || $past(bus_wr, 2))
    else $error("End of conversion rose without a trigger.");
  a_fail_excl: assert property (
    !fail_n |-> &outs[3:1]) else $error("Fail shown beside a pass output.");
  a_busy_no_eoc: assert property (
    sampling |-> eoc_n) else $error("End of conversion low while sampling.");
  a_result_settle: assert property (
    !$stable(outs) |-> eoc_n && lo_ff >= SET_MIN) else $error("Result changed too early.");
  a_proc_floor: assert property (
    s_done |-> lo_ff >= PROC_MIN) else $error("Processing time too short.");
  a_samp_floor: assert property (
    $fell(sampling) |-> hi_ff >= SAMP_MIN) else $error("Sampling time too short.");
  a_supply_wr: assert property (
    $changed(handler_supply_select) |-> $past(bus_wr) || $past(bus_wr, 2))
    else $error("Supply selection changed without a write.");
  a_beeper_wr: assert property (
    $changed(beeper_en) |-> $past(bus_wr) || $past(bus_wr, 2))
    else $error("Beeper setting changed without a write.");
endmodule

bind shs_sequencer shs_checker #(.US_CYCLES(US_CYCLES)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .meas_trig_n(meas_trig_n), .bin1_good_n(bin1_good_n), .bin2_good_n(bin2_good_n),
  .bin3_good_n(bin3_good_n), .fail_n(fail_n), .eoc_n(eoc_n), .beeper_en(beeper_en),
  .handler_supply_select(handler_supply_select), .sampling(sampling));

/* verif/shs_handler_model.sv */
// Behavioural sorting handler that pulses the measurement trigger.
`timescale 1ns/10ps
module shs_handler_model #(
  parameter int LOW_CYC = 1000
) (
  // Clock and request.
  input wire logic core_clk,
  input wire logic go,
  // Handler pin.
  output logic     meas_trig_n
);
  int n;
  initial meas_trig_n = 1'b1;
  always @(posedge core_clk) begin
    if (go === 1'b1) begin
      meas_trig_n <= 1'b0;
      for (n = 0; n < LOW_CYC; n++) begin
        @(posedge core_clk);
      end
      meas_trig_n <= 1'b1;
    end
  end
endmodule

/* verif/sorting_handler_sequencer_bench.sv */
// Self-checking bench for the sorting handler sequencer.
`timescale 1ns/10ps
module sorting_handler_sequencer_bench;
  import shs_pkg::*;
  // ==========================================================
  // Signals, model state and measurement table.
  localparam int          US        = 1;
  localparam logic [31:0] MCTRL [4] = '{32'h1a0, 32'h021, 32'h025, 32'h02b};
  localparam logic [31:0] MLF [4]   = '{32'h32, 32'h32, 32'h32, 32'h3c};
  localparam int          MDLY [4]  = '{0, 1, 1, 0};
  localparam int          MSAMP [4] = '{5000, 5000, 11000, 16600};
  logic core_clk, reset_n, psel, penable, pwrite, go, err, pready, pslverr, meas_trig_n;
  logic bin1_good_n, bin2_good_n, bin3_good_n, fail_n, eoc_n, handler_supply_select;
  logic beeper_en, sampling;
  logic [7:0]   paddr;
  logic [2:0]   bin_judge;
  logic [31:0]  pwdata, prdata, rd, m_ctrl, m_lf, m_dly, m_en, seed, ok;
  logic [127:0] sv [32];
  int           n_errors, total_checks;
  shs_sequencer #(.US_CYCLES(US)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bin_judge(bin_judge), .meas_trig_n(meas_trig_n),
    .bin1_good_n(bin1_good_n), .bin2_good_n(bin2_good_n), .bin3_good_n(bin3_good_n),
    .fail_n(fail_n), .eoc_n(eoc_n), .handler_supply_select(handler_supply_select),
    .beeper_en(beeper_en), .sampling(sampling));
  shs_handler_model #(.LOW_CYC(1000 * US)) u_hdl (
    .core_clk(core_clk), .go(go), .meas_trig_n(meas_trig_n));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #(8 * 110000);
    n_errors++;
    results();
  end
  // ==========================================================
  // Helpers.
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    chk_reg({28'h0, got}, {28'h0, exp});
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] mreg(input logic [7:0] a);
    case (a)
      SHS_CTRL_OFS:  return m_ctrl;
      SHS_LFREQ_OFS: return m_lf;
      SHS_DELAY_OFS: return m_dly;
      SHS_BINEN_OFS: return m_en;
      default:       return 32'h0;
    endcase
  endfunction
  task automatic mwr(input logic [7:0] a, input logic [31:0] d);
    logic [4:0] s;
    s = d[12:8];
    case (a)
      SHS_CTRL_OFS:  m_ctrl = {22'h0, d[9:0]};
      SHS_LFREQ_OFS: if (d == 32'h32 || d == 32'h3c) m_lf = d;
      SHS_DELAY_OFS: m_dly = {16'h0, d[15:0]};
      SHS_BINEN_OFS: m_en = {29'h0, d[2:0]};
      SHS_CMD_OFS: begin
        if (d[2] && s >= 1 && s <= 30 && d[20:16] >= 1 && d[20:16] <= 15) begin
          sv[s] = {m_ctrl, m_lf, m_dly, m_en};
          ok[s] = 1'b1;
        end
        if (d[1]) {m_ctrl, m_lf, m_dly, m_en} = {32'h23, 32'h32, 32'h0, 32'h7};
        else if (d[3] && ok[s]) {m_ctrl, m_lf, m_dly, m_en} = sv[s];
      end
      default: ;
    endcase
    apb(1'b1, a, d);
  endtask
  task automatic chk_all();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk_reg(rd, mreg(8'(i * 4)));
      chk_pin({3'h0, err}, 4'h0);
    end
  endtask
  task automatic meas(input int i);
    int n, lo;
    logic [31:0] r;
    logic [2:0] g;
    mwr(SHS_CTRL_OFS, MCTRL[i]);
    mwr(SHS_LFREQ_OFS, MLF[i]);
    mwr(SHS_DELAY_OFS, 32'(MDLY[i]));
    mwr(SHS_BINEN_OFS, rnd() & 32'h7);
    r = rnd();
    g = r[2:0] & m_en[2:0];
    bin_judge <= r[2:0];
    if (MCTRL[i][8]) apb(1'b1, SHS_CMD_OFS, 32'h1);
    else begin
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
    end
    lo = (1000 * MDLY[i] + MSAMP[i] + (MCTRL[i][1] ? SHS_T_PROC_ON_US : SHS_T_PROC_OFF_US)) * US;
    n = 0;
    while (eoc_n !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk_pin({eoc_n, 3'h0}, 4'h8);
    while (eoc_n !== 1'b0 && n < lo + 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk_reg(32'(n >= lo - 4 && n <= lo + 64), 32'h1);
    @(negedge core_clk);
    chk_pin({bin1_good_n, bin2_good_n, bin3_good_n, fail_n},
            {~g[0], ~g[1], ~g[2], |g});
    apb(1'b0, SHS_STATUS_OFS, 32'h0);
    chk_reg(rd, {24'h0, 1'b1, MCTRL[i][8], 6'h0});
    apb(1'b0, SHS_RESULT_OFS, 32'h0);
    chk_reg(rd, {28'h0, MCTRL[i][8], g});
    $display("test measurement %0d done", i);
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    {psel, penable, pwrite, go, paddr, pwdata, bin_judge, ok, n_errors, total_checks} = '0;
    {m_ctrl, m_lf, m_dly, m_en} = {32'h23, 32'h32, 32'h0, 32'h7};
    seed = 32'h0246;
    reset_n = 1'b0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk_pin({beeper_en, handler_supply_select, eoc_n, sampling}, 4'ha);
    chk_all();
    mwr(8'h1c, 32'hffff_ffff);
    chk_pin({3'h0, err}, 4'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk_reg(rd, 32'h0);
    chk_all();
    $display("test reset done");
    mwr(SHS_LFREQ_OFS, 32'h3c);
    mwr(SHS_LFREQ_OFS, 32'h33);
    mwr(SHS_CTRL_OFS, 32'h041);
    @(negedge core_clk);
    chk_pin({beeper_en, handler_supply_select, 2'h0}, 4'h4);
    mwr(SHS_CMD_OFS, 32'h0008_1e04);
    mwr(SHS_CMD_OFS, 32'h0010_0904);
    mwr(SHS_CTRL_OFS, 32'h0a3);
    mwr(SHS_DELAY_OFS, 32'h3);
    mwr(SHS_CMD_OFS, 32'h0000_0708);
    mwr(SHS_CMD_OFS, 32'h0000_0908);
    chk_all();
    mwr(SHS_CMD_OFS, 32'h0000_1e08);
    chk_all();
    mwr(SHS_CMD_OFS, 32'h2);
    chk_all();
    $display("test settings done");
    mwr(SHS_CTRL_OFS, 32'h021);
    mwr(SHS_CMD_OFS, 32'h1);
    repeat (20) @(posedge core_clk);
    chk_pin({eoc_n, sampling, 2'h0}, 4'h8);
    $display("test refused trigger done");
    for (int i = 0; i < 4; i++) meas(i);
    results();
  end
endmodule
